// ### design/boot_id_pkg.sv
// Package with the address map, field layout and reset values of the start-up and identification bank.
package boot_id_pkg;

	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned RETRY_W = 5;

	// Offsets of the registers held in this bank.
	localparam logic [15:0] OFS_BOOT_SOURCE_AND_RETRY    = 16'h0000;
	localparam logic [15:0] OFS_EEPROM_BUS_ADDRESS_CFG   = 16'h0001;
	localparam logic [15:0] OFS_REVISION_AND_PART_HIGH   = 16'h0002;
	localparam logic [15:0] OFS_PART_IDENTIFIER_MID      = 16'h0003;
	localparam logic [15:0] OFS_PART_LOW_AND_CONFIG_HIGH = 16'h0004;
	localparam logic [15:0] OFS_FACTORY_CONFIG_CODE_LOW  = 16'h0005;

	// Upper bound of each block in the control and status spaces.
	localparam logic [15:0] END_STARTUP    = 16'h0001;
	localparam logic [15:0] END_IDENT      = 16'h0005;
	localparam logic [15:0] END_SERIAL     = 16'h0007;
	localparam logic [15:0] END_DPLL0      = 16'h003A;
	localparam logic [15:0] END_DPLL1      = 16'h006D;
	localparam logic [15:0] END_GPIO       = 16'h0076;
	localparam logic [15:0] END_OUTPUT     = 16'h00AB;
	localparam logic [15:0] END_APLL0      = 16'h00AF;
	localparam logic [15:0] END_APLL1      = 16'h00B3;
	localparam logic [15:0] END_PWRDN      = 16'h00B8;
	localparam logic [15:0] END_INMON      = 16'h00C6;
	localparam logic [15:0] END_IRQ_EN     = 16'h00C7;
	localparam logic [15:0] END_PHASE_DET  = 16'h00CB;
	localparam logic [15:0] END_CTRL_RSVD  = 16'h01FF;
	localparam logic [15:0] END_IRQ_STAT   = 16'h0203;
	localparam logic [15:0] END_OUT_PHASE  = 16'h0204;
	localparam logic [15:0] END_DPLL0_STAT = 16'h020E;
	localparam logic [15:0] END_DPLL1_STAT = 16'h0218;
	localparam logic [15:0] END_GPI_STAT   = 16'h0219;
	localparam logic [15:0] END_GLOBAL     = 16'h021F;
	localparam logic [15:0] END_STAT_RSVD  = 16'h03FF;

	// Field positions inside the start-up and identification bytes.
	localparam int unsigned POS_RETRY_LSB   = 3;
	localparam int unsigned POS_RSVD_BOOT   = 2;
	localparam int unsigned POS_OTP_SEL_N   = 1;
	localparam int unsigned POS_EXT_SEL_N   = 0;
	localparam int unsigned POS_WIDE_PAGE   = 7;
	localparam int unsigned POS_CODE_ONE    = 0;

	// Values after reset that are fixed constants.
	localparam logic [4:0] RST_RETRY    = 5'h01;
	localparam logic [7:0] RST_ZERO     = 8'h00;
	localparam logic [0:0] CODE_LSB_ONE = 1'h1;

	typedef enum logic [4:0] {
		BLK_STARTUP, BLK_IDENT, BLK_SERIAL, BLK_DPLL0, BLK_DPLL1, BLK_GPIO,
		BLK_OUTPUT, BLK_APLL0, BLK_APLL1, BLK_PWRDN, BLK_INMON, BLK_IRQ_EN,
		BLK_PHASE_DET, BLK_IRQ_STAT, BLK_OUT_PHASE, BLK_DPLL0_STAT,
		BLK_DPLL1_STAT, BLK_GPI_STAT, BLK_GLOBAL, BLK_RESERVED
	} block_t;

endpackage : boot_id_pkg

// ### design/boot_retry_tracker.sv
// Arbitration retry and abort tracking for the external boot memory read.
`timescale 1ns/1ps
`default_nettype none
module boot_retry_tracker
	import boot_id_pkg::*;
(
	input  wire logic               core_clk,
	input  wire logic               rst,
	input  wire logic               boot_start,
	input  wire logic [RETRY_W-1:0] retry_limit,
	input  wire logic               arb_lost,
	input  wire logic               slave_nack,
	input  wire logic               addr_collision,
	input  wire logic               crc_mismatch,
	input  wire logic               response_timeout,
	input  wire logic               failure_clear,
	output logic                    retry_request,
	output logic                    boot_abort,
	output logic                    boot_load_failure
);

	logic [RETRY_W-1:0] retries_left;
	logic               hard_fault;
	logic               out_of_retries;
	logic               abort_now;

	assign hard_fault     = slave_nack | addr_collision | crc_mismatch | response_timeout;
	assign out_of_retries = arb_lost && (retries_left == '0);
	assign abort_now      = hard_fault | out_of_retries;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			retries_left <= RST_RETRY;
		end else if (boot_start) begin
			retries_left <= retry_limit;
		end else if (arb_lost && retries_left != '0) begin
			retries_left <= retries_left - 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			retry_request     <= 1'b0;
			boot_abort        <= 1'b0;
			boot_load_failure <= 1'b0;
		end else begin
			retry_request <= arb_lost && !abort_now && !boot_start;
			boot_abort    <= abort_now && !boot_start;
			// A fault in the same cycle as a clear still leaves the flag set.
			if (abort_now && !boot_start) begin
				boot_load_failure <= 1'b1;
			end else if (failure_clear || boot_start) begin
				boot_load_failure <= 1'b0;
			end
		end
	end

endmodule : boot_retry_tracker
`default_nettype wire

// ### design/startup_and_id_register_bank.sv
// Start-up boot controls, identification bytes and top-level address decode.
`timescale 1ns/1ps
`default_nettype none
module startup_and_id_register_bank
	import boot_id_pkg::*;
#(
	// Arbitrary neutral identity values.
	parameter logic [3:0]  REVISION_ID = 4'h0,
	parameter logic [15:0] PART_ID     = 16'h0000
) (
	input  wire logic                core_clk,
	input  wire logic                rst,
	input  wire logic                addr_load,
	input  wire logic [ADDR_W-1:0]   addr_start,
	input  wire logic                wr_strobe,
	input  wire logic [DATA_W-1:0]   wr_data,
	input  wire logic                rd_strobe,
	input  wire logic                boot_busy,
	input  wire logic                factory_otp_select_n,
	input  wire logic                factory_ext_select_n,
	input  wire logic                factory_wide_page,
	input  wire logic [6:0]          factory_bus_address,
	input  wire logic [10:0]         factory_config_code,
	input  wire logic                boot_start,
	input  wire logic                arb_lost,
	input  wire logic                slave_nack,
	input  wire logic                addr_collision,
	input  wire logic                crc_mismatch,
	input  wire logic                response_timeout,
	input  wire logic                failure_clear,
	output logic [DATA_W-1:0]        rd_data,
	output logic                     rd_valid,
	output logic [ADDR_W-1:0]        cur_addr,
	output block_t                   cur_block,
	output logic                     bank_hit,
	output logic                     reserved_hit,
	output logic [RETRY_W-1:0]       arbitration_retry_count,
	output logic                     otp_boot_select_n,
	output logic                     ext_boot_select_n,
	output logic                     wide_page_addressing,
	output logic [6:0]               boot_memory_bus_address,
	output logic [10:0]              config_code,
	output logic                     otp_full_load,
	output logic                     ext_boot_enable,
	output logic                     retry_request,
	output logic                     boot_abort,
	output logic                     boot_load_failure
);

	// Maps a register address onto the functional block that owns it.
	function automatic block_t decode_block(input logic [ADDR_W-1:0] a);
		block_t b;
		b = BLK_RESERVED;
		if (a <= END_STARTUP)           b = BLK_STARTUP;
		else if (a <= END_IDENT)        b = BLK_IDENT;
		else if (a <= END_SERIAL)       b = BLK_SERIAL;
		else if (a <= END_DPLL0)        b = BLK_DPLL0;
		else if (a <= END_DPLL1)        b = BLK_DPLL1;
		else if (a <= END_GPIO)         b = BLK_GPIO;
		else if (a <= END_OUTPUT)       b = BLK_OUTPUT;
		else if (a <= END_APLL0)        b = BLK_APLL0;
		else if (a <= END_APLL1)        b = BLK_APLL1;
		else if (a <= END_PWRDN)        b = BLK_PWRDN;
		else if (a <= END_INMON)        b = BLK_INMON;
		else if (a <= END_IRQ_EN)       b = BLK_IRQ_EN;
		else if (a <= END_PHASE_DET)    b = BLK_PHASE_DET;
		else if (a <= END_CTRL_RSVD)    b = BLK_RESERVED;
		else if (a <= END_IRQ_STAT)     b = BLK_IRQ_STAT;
		else if (a <= END_OUT_PHASE)    b = BLK_OUT_PHASE;
		else if (a <= END_DPLL0_STAT)   b = BLK_DPLL0_STAT;
		else if (a <= END_DPLL1_STAT)   b = BLK_DPLL1_STAT;
		else if (a <= END_GPI_STAT)     b = BLK_GPI_STAT;
		else if (a <= END_GLOBAL)       b = BLK_GLOBAL;
		return b;
	endfunction : decode_block

	// Stored bytes of the bank.
	logic [RETRY_W-1:0] retry_field;
	logic               boot_rsvd;
	logic               otp_sel_n;
	logic               ext_sel_n;
	logic               wide_page;
	logic [6:0]         mem_addr;
	logic [3:0]         revision_field;
	logic [15:0]        part_identifier;
	logic [10:0]        code_field;
	logic [ADDR_W-1:0]  addr_ptr;

	// Decode of the current pointer.
	logic        access_ok;
	logic        do_write;
	logic        do_read;
	logic        sel_boot_src;
	logic        sel_mem_cfg;
	logic        sel_rev_part;
	logic        sel_part_mid;
	logic        sel_part_code;
	logic        sel_code_low;
	logic [7:0]  next_rd_data;
	block_t      ptr_block;
	logic        wr_boot_src;
	logic        wr_mem_cfg;
	logic        wr_rev_part;
	logic        wr_part_mid;
	logic        wr_part_code;
	logic        wr_code_low;
	logic        ptr_in_bank;

	// While the boot loader owns the bus the serial port is not answered.
	assign access_ok     = !boot_busy;
	assign do_write      = wr_strobe && access_ok;
	assign do_read       = rd_strobe && access_ok;
	assign ptr_block     = decode_block(addr_ptr);
	assign sel_boot_src  = addr_ptr == OFS_BOOT_SOURCE_AND_RETRY;
	assign sel_mem_cfg   = addr_ptr == OFS_EEPROM_BUS_ADDRESS_CFG;
	assign sel_rev_part  = addr_ptr == OFS_REVISION_AND_PART_HIGH;
	assign sel_part_mid  = addr_ptr == OFS_PART_IDENTIFIER_MID;
	assign sel_part_code = addr_ptr == OFS_PART_LOW_AND_CONFIG_HIGH;
	assign sel_code_low  = addr_ptr == OFS_FACTORY_CONFIG_CODE_LOW;
	// Addresses are compared whole, so a high offset never aliases onto the bank.
	assign ptr_in_bank   = ptr_block == BLK_STARTUP || ptr_block == BLK_IDENT;

	// Write enables per byte; a write that matches no byte here is dropped.
	assign wr_boot_src   = do_write && sel_boot_src;
	assign wr_mem_cfg    = do_write && sel_mem_cfg;
	assign wr_rev_part   = do_write && sel_rev_part;
	assign wr_part_mid   = do_write && sel_part_mid;
	assign wr_part_code  = do_write && sel_part_code;
	assign wr_code_low   = do_write && sel_code_low;

	// Read multiplexer; other blocks read as zero from this bank.
	always_comb begin
		next_rd_data = RST_ZERO;
		if (sel_boot_src) begin
			next_rd_data = {retry_field, boot_rsvd, otp_sel_n, ext_sel_n};
		end else if (sel_mem_cfg) begin
			next_rd_data = {wide_page, mem_addr};
		end else if (sel_rev_part) begin
			next_rd_data = {revision_field, part_identifier[15:12]};
		end else if (sel_part_mid) begin
			next_rd_data = part_identifier[11:4];
		end else if (sel_part_code) begin
			next_rd_data = {part_identifier[3:0], code_field[10:7]};
		end else if (sel_code_low) begin
			next_rd_data = {code_field[6:0], CODE_LSB_ONE};
		end
	end

	// Address pointer for block transfers.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			addr_ptr <= '0;
		end else if (addr_load && access_ok) begin
			addr_ptr <= addr_start;
		end else if (do_write || do_read) begin
			addr_ptr <= addr_ptr + 1'b1;
		end
	end

	// Start-up byte zero, retry field and reserved bit.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			retry_field <= RST_RETRY;
			boot_rsvd   <= 1'b0;
		end else if (wr_boot_src) begin
			retry_field <= wr_data[POS_RETRY_LSB +: RETRY_W];
			boot_rsvd   <= wr_data[POS_RSVD_BOOT];
		end
	end

	// Boot selects; factory values are loaded in the reset cycle.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			otp_sel_n <= factory_otp_select_n;
			ext_sel_n <= factory_ext_select_n;
		end else if (wr_boot_src) begin
			otp_sel_n <= wr_data[POS_OTP_SEL_N];
			ext_sel_n <= wr_data[POS_EXT_SEL_N];
		end
	end

	// Start-up byte one, wide addressing flag.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			wide_page <= factory_wide_page;
		end else if (wr_mem_cfg) begin
			wide_page <= wr_data[POS_WIDE_PAGE];
		end
	end

	// Start-up byte one, boot memory bus address.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			mem_addr <= factory_bus_address;
		end else if (wr_mem_cfg) begin
			mem_addr <= wr_data[6:0];
		end
	end

	// Revision nibble.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			revision_field <= REVISION_ID;
		end else if (wr_rev_part) begin
			revision_field <= wr_data[7:4];
		end
	end

	// Part identifier, spread over three bytes.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			part_identifier <= PART_ID;
		end else if (wr_rev_part) begin
			part_identifier[15:12] <= wr_data[3:0];
		end else if (wr_part_mid) begin
			part_identifier[11:4] <= wr_data;
		end else if (wr_part_code) begin
			part_identifier[3:0] <= wr_data[7:4];
		end
	end

	// Configuration code; bit zero of its low byte reads as one and takes no write.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			code_field <= factory_config_code;
		end else if (wr_part_code) begin
			code_field[10:7] <= wr_data[3:0];
		end else if (wr_code_low) begin
			code_field[6:0] <= wr_data[7:1];
		end
	end

	// Read data is registered and stands until the next read.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rd_data  <= RST_ZERO;
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= do_read;
			if (do_read) begin
				rd_data <= next_rd_data;
			end
		end
	end

	// Block decode of the pointer, one cycle behind it.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cur_block    <= BLK_STARTUP;
			bank_hit     <= 1'b0;
			reserved_hit <= 1'b0;
		end else begin
			cur_block    <= ptr_block;
			bank_hit     <= ptr_in_bank;
			reserved_hit <= ptr_block == BLK_RESERVED;
		end
	end

	assign cur_addr                = addr_ptr;
	assign arbitration_retry_count = retry_field;
	assign otp_boot_select_n       = otp_sel_n;
	assign ext_boot_select_n       = ext_sel_n;
	assign wide_page_addressing    = wide_page;
	assign boot_memory_bus_address = mem_addr;
	assign config_code             = code_field;
	assign otp_full_load           = !otp_sel_n;
	assign ext_boot_enable         = !ext_sel_n;

	// Retry accounting for the boot loader; a limit of zero aborts on the first loss.
	boot_retry_tracker i_boot_retry_tracker (
		.core_clk          (core_clk),
		.rst               (rst),
		.boot_start        (boot_start),
		.retry_limit       (retry_field),
		.arb_lost          (arb_lost),
		.slave_nack        (slave_nack),
		.addr_collision    (addr_collision),
		.crc_mismatch      (crc_mismatch),
		.response_timeout  (response_timeout),
		.failure_clear     (failure_clear),
		.retry_request     (retry_request),
		.boot_abort        (boot_abort),
		.boot_load_failure (boot_load_failure)
	);

endmodule : startup_and_id_register_bank
`default_nettype wire

// ### tb/startup_and_id_register_bank_asserts.sv
// Concurrent checks on the ports of the start-up and identification bank.
`timescale 1ns/1ps
`default_nettype none
module startup_and_id_register_bank_asserts
	import boot_id_pkg::*;
(
	input wire logic               core_clk,
	input wire logic               rst,
	input wire logic               addr_load,
	input wire logic               wr_strobe,
	input wire logic [DATA_W-1:0]  wr_data,
	input wire logic               rd_strobe,
	input wire logic               boot_busy,
	input wire logic               factory_otp_select_n,
	input wire logic [6:0]         factory_bus_address,
	input wire logic               boot_start,
	input wire logic               arb_lost,
	input wire logic               slave_nack,
	input wire logic               addr_collision,
	input wire logic               crc_mismatch,
	input wire logic               response_timeout,
	input wire logic [DATA_W-1:0]  rd_data,
	input wire logic               rd_valid,
	input wire logic [ADDR_W-1:0]  cur_addr,
	input wire block_t             cur_block,
	input wire logic [RETRY_W-1:0] arbitration_retry_count,
	input wire logic               otp_boot_select_n,
	input wire logic               ext_boot_select_n,
	input wire logic               wide_page_addressing,
	input wire logic [6:0]         boot_memory_bus_address,
	input wire logic [10:0]        config_code,
	input wire logic               otp_full_load,
	input wire logic               ext_boot_enable,
	input wire logic               retry_request,
	input wire logic               boot_abort,
	input wire logic               boot_load_failure
);
	default clocking cb @(posedge core_clk);
	endclocking
	wire acc   = !rst && !boot_busy;
	wire wr_ok = acc && wr_strobe;
	wire rd_ok = acc && rd_strobe;
	wire hard  = slave_nack || addr_collision || crc_mismatch || response_timeout;
	a_retry_reset_one: assert property (rst |=> arbitration_retry_count == RST_RETRY)
		else $error("retry count not one after reset");
	a_factory_reload: assert property (rst |=> otp_boot_select_n == $past(factory_otp_select_n)
		&& boot_memory_bus_address == $past(factory_bus_address)) else $error("factory value not loaded");
	a_select_levels: assert property (disable iff (rst)
		otp_full_load == !otp_boot_select_n && ext_boot_enable == !ext_boot_select_n) else $error("select level wrong");
	a_boot_byte_write: assert property (disable iff (rst) wr_ok && cur_addr == OFS_BOOT_SOURCE_AND_RETRY |=>
		{arbitration_retry_count, 1'b0, otp_boot_select_n, ext_boot_select_n} == ($past(wr_data) & 8'hFB))
		else $error("start-up byte not written");
	a_mem_addr_write: assert property (disable iff (rst) wr_ok && cur_addr == OFS_EEPROM_BUS_ADDRESS_CFG |=>
		{wide_page_addressing, boot_memory_bus_address} == $past(wr_data)) else $error("address byte not written");
	a_code_low_read: assert property (disable iff (rst) rd_ok && !wr_strobe && cur_addr == OFS_FACTORY_CONFIG_CODE_LOW
		|=> rd_data == {config_code[6:0], 1'b1}) else $error("code byte read wrong");
	a_read_valid_pulse: assert property (disable iff (rst) 1'b1 |=> rd_valid == $past(rd_ok))
		else $error("read valid misplaced");
	a_pointer_step: assert property (disable iff (rst) (wr_ok || rd_ok) && !addr_load |=>
		cur_addr == $past(cur_addr) + 16'h0001) else $error("pointer did not step");
	a_hard_abort: assert property (disable iff (rst) hard && !boot_start |=> boot_abort && boot_load_failure)
		else $error("fault did not abort");
	a_zero_budget: assert property (disable iff (rst) boot_start && arbitration_retry_count == 5'h00 ##1
		arb_lost && !boot_start |=> boot_abort && !retry_request) else $error("zero budget retried");
	a_status_decode: assert property (disable iff (rst) $past(cur_addr) >= 16'h021A
		&& $past(cur_addr) <= END_GLOBAL |-> cur_block == BLK_GLOBAL) else $error("status block wrong");
	a_control_decode: assert property (disable iff (rst) $past(cur_addr) >= 16'h0008
		&& $past(cur_addr) <= END_DPLL0 |-> cur_block == BLK_DPLL0) else $error("control block wrong");
endmodule : startup_and_id_register_bank_asserts
bind startup_and_id_register_bank startup_and_id_register_bank_asserts i_chk (.core_clk(core_clk), .rst(rst),
	.addr_load(addr_load), .wr_strobe(wr_strobe), .wr_data(wr_data), .rd_strobe(rd_strobe), .boot_busy(boot_busy),
	.factory_otp_select_n(factory_otp_select_n), .factory_bus_address(factory_bus_address), .boot_start(boot_start),
	.arb_lost(arb_lost), .slave_nack(slave_nack), .addr_collision(addr_collision), .crc_mismatch(crc_mismatch),
	.response_timeout(response_timeout), .rd_data(rd_data), .rd_valid(rd_valid), .cur_addr(cur_addr),
	.cur_block(cur_block), .arbitration_retry_count(arbitration_retry_count), .otp_boot_select_n(otp_boot_select_n),
	.ext_boot_select_n(ext_boot_select_n), .wide_page_addressing(wide_page_addressing),
	.boot_memory_bus_address(boot_memory_bus_address), .config_code(config_code), .otp_full_load(otp_full_load),
	.ext_boot_enable(ext_boot_enable), .retry_request(retry_request), .boot_abort(boot_abort),
	.boot_load_failure(boot_load_failure));
`default_nettype wire

// ### tb/boot_fault_model.sv
// Boot bus fault source standing in for the arbitration and boot memory side.
`timescale 1ns/1ps
`default_nettype none
module boot_fault_model (
	input  wire logic core_clk,
	output logic      arb_lost,
	output logic      slave_nack,
	output logic      addr_collision,
	output logic      crc_mismatch,
	output logic      response_timeout
);
	initial begin
		{arb_lost, slave_nack, addr_collision, crc_mismatch, response_timeout} = 5'h00;
	end
	// Called at a falling edge; the bus flags each fault for exactly one cycle, never as a level.
	task automatic hit(input int kind);
		{arb_lost, slave_nack, addr_collision, crc_mismatch, response_timeout} = 5'h10 >> kind;
		@(negedge core_clk);
		{arb_lost, slave_nack, addr_collision, crc_mismatch, response_timeout} = 5'h00;
	endtask : hit
endmodule : boot_fault_model
`default_nettype wire

// ### tb/startup_and_id_register_bank_tb.sv
// Self-checking bench for the start-up and identification register bank.
`timescale 1ns/1ps
`default_nettype none
module startup_and_id_register_bank_tb;
	import boot_id_pkg::*;
	localparam logic [3:0]  REV  = 4'hA;     // Arbitrary revision value.
	localparam logic [15:0] PART = 16'h3C5A; // Arbitrary part value.
	logic core_clk, rst, addr_load, wr_strobe, rd_strobe, boot_busy, boot_start, failure_clear, f_otp_n, f_ext_n, f_wide;
	logic arb_lost, slave_nack, addr_collision, crc_mismatch, response_timeout, rd_valid, bank_hit, reserved_hit;
	logic otp_boot_select_n, ext_boot_select_n, wide_page_addressing, otp_full_load, ext_boot_enable;
	logic retry_request, boot_abort, boot_load_failure;
	logic [15:0] addr_start, cur_addr;
	logic [7:0]  wr_data, rd_data;
	logic [6:0]  f_addr, boot_memory_bus_address;
	logic [10:0] f_code, config_code;
	logic [4:0]  arbitration_retry_count;
	block_t      cur_block;
	int          n_errors = 0;
	int          n_checks = 0;
	logic [15:0] rq[$];
	logic [1:0]  eq[$];
	logic [7:0]  d[6];
	logic [15:0] ta[10] = '{16'h0000, 16'h0005, 16'h0006, 16'h0008, 16'h003B, 16'h00C7, 16'h0100, 16'h0203, 16'h021A, 16'h0300};
	block_t      tk[10] = '{BLK_STARTUP, BLK_IDENT, BLK_SERIAL, BLK_DPLL0, BLK_DPLL1, BLK_IRQ_EN, BLK_RESERVED,
		BLK_IRQ_STAT, BLK_GLOBAL, BLK_RESERVED};
	startup_and_id_register_bank #(.REVISION_ID(REV), .PART_ID(PART)) i_startup_and_id_register_bank (
		.core_clk(core_clk), .rst(rst), .addr_load(addr_load), .addr_start(addr_start), .wr_strobe(wr_strobe),
		.wr_data(wr_data), .rd_strobe(rd_strobe), .boot_busy(boot_busy), .factory_otp_select_n(f_otp_n),
		.factory_ext_select_n(f_ext_n), .factory_wide_page(f_wide), .factory_bus_address(f_addr),
		.factory_config_code(f_code), .boot_start(boot_start), .arb_lost(arb_lost), .slave_nack(slave_nack),
		.addr_collision(addr_collision), .crc_mismatch(crc_mismatch), .response_timeout(response_timeout),
		.failure_clear(failure_clear), .rd_data(rd_data), .rd_valid(rd_valid), .cur_addr(cur_addr),
		.cur_block(cur_block), .bank_hit(bank_hit), .reserved_hit(reserved_hit),
		.arbitration_retry_count(arbitration_retry_count), .otp_boot_select_n(otp_boot_select_n),
		.ext_boot_select_n(ext_boot_select_n), .wide_page_addressing(wide_page_addressing),
		.boot_memory_bus_address(boot_memory_bus_address), .config_code(config_code), .otp_full_load(otp_full_load),
		.ext_boot_enable(ext_boot_enable), .retry_request(retry_request), .boot_abort(boot_abort),
		.boot_load_failure(boot_load_failure));
	boot_fault_model i_boot_fault_model (.core_clk(core_clk), .arb_lost(arb_lost), .slave_nack(slave_nack),
		.addr_collision(addr_collision), .crc_mismatch(crc_mismatch), .response_timeout(response_timeout));
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	task automatic stop_test();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// Every call sets all three strobes once, so back-to-back requests never drive one signal twice per step.
	task automatic op(input logic l, input logic w, input logic r, input logic [15:0] a, input logic [7:0] v);
		addr_load = l;
		wr_strobe = w;
		rd_strobe = r;
		addr_start = a;
		wr_data = v;
		@(negedge core_clk);
	endtask : op
	task automatic rd(input logic [7:0] exp, input logic [7:0] mask);
		rq.push_back({mask, exp & mask});
		op(1'b0, 1'b0, 1'b1, 16'h0000, 8'h00);
	endtask : rd
	task automatic pulse_clear();
		failure_clear = 1'b1;
		@(negedge core_clk);
		failure_clear = 1'b0;
		chk("failure_cleared", 16'h0000, 16'(boot_load_failure));
	endtask : pulse_clear
	always @(negedge core_clk) begin
		if (!rst && rd_valid === 1'b1) begin
			if (rq.size() == 0) chk("rd_valid", 16'h0000, 16'h0001);
			else chk("rd_data", {8'h00, rq[0][7:0]}, {8'h00, rd_data & rq[0][15:8]});
			if (rq.size() != 0) void'(rq.pop_front());
		end
		if (!rst && (boot_abort === 1'b1 || retry_request === 1'b1)) begin
			if (eq.size() == 0) chk("boot_event", 16'h0000, 16'({boot_abort, retry_request}));
			else chk("boot_event", 16'(eq.pop_front()), 16'({boot_abort, retry_request}));
		end
	end
	initial begin
		repeat (5000) @(posedge core_clk);
		n_errors++;
		$display("Error watchdog expected done seen hang");
		stop_test();
	end
	initial begin
		{rst, boot_busy, boot_start, failure_clear} = 4'h8;
		{addr_load, wr_strobe, rd_strobe, addr_start, wr_data} = 27'h000_0000;
		void'($urandom(81340));
		{f_otp_n, f_ext_n, f_wide, f_addr, f_code} = 21'($urandom());
		repeat (12) @(negedge core_clk);
		rst = 1'b0;
		op(1'b1, 1'b0, 1'b0, OFS_BOOT_SOURCE_AND_RETRY, 8'h00);
		rd({RST_RETRY, 1'b0, f_otp_n, f_ext_n}, 8'hFB);
		rd({f_wide, f_addr}, 8'hFF);
		rd({REV, PART[15:12]}, 8'hFF);
		rd(PART[11:4], 8'hFF);
		rd({PART[3:0], f_code[10:7]}, 8'hFF);
		rd({f_code[6:0], 1'b1}, 8'hFF);
		op(1'b1, 1'b0, 1'b0, 16'h0000, 8'h00);
		for (int i = 0; i < 6; i++) d[i] = 8'($urandom());
		d[0][2] = 1'b0;
		for (int i = 0; i < 6; i++) op(1'b0, 1'b1, 1'b0, 16'h0000, d[i]);
		op(1'b1, 1'b0, 1'b0, 16'h0000, 8'h00);
		rd(d[0], 8'hFB);
		for (int i = 1; i < 5; i++) rd(d[i], 8'hFF);
		rd({d[5][7:1], 1'b1}, 8'hFF);
		chk("retry", 16'(d[0][7:3]), 16'(arbitration_retry_count));
		chk("otp_full", 16'(!d[0][1]), 16'(otp_full_load));
		chk("ext_en", 16'(!d[0][0]), 16'(ext_boot_enable));
		chk("wide", 16'(d[1][7]), 16'(wide_page_addressing));
		chk("bus_addr", 16'(d[1][6:0]), 16'(boot_memory_bus_address));
		chk("code", 16'({d[4][3:0], d[5][7:1]}), 16'(config_code));
		for (int i = 0; i < 10; i++) begin
			op(1'b1, 1'b0, 1'b0, ta[i], 8'h00);
			op(1'b0, 1'b0, 1'b0, 16'h0000, 8'h00);
			chk("cur_block", 16'(tk[i]), 16'(cur_block));
			chk("reserved_hit", 16'(tk[i] == BLK_RESERVED), 16'(reserved_hit));
			chk("bank_hit", 16'(ta[i] <= END_IDENT), 16'(bank_hit));
		end
		op(1'b0, 1'b1, 1'b0, 16'h0000, 8'h00);
		rd(8'h00, 8'hFF);
		boot_busy = 1'b1;
		op(1'b1, 1'b0, 1'b0, 16'h0000, 8'h00);
		op(1'b0, 1'b1, 1'b0, 16'h0000, ~d[0]);
		boot_busy = 1'b0;
		op(1'b1, 1'b0, 1'b0, 16'h0000, 8'h00);
		rd(d[0], 8'hFB);
		for (int n = 0; n < 3; n += 2) begin
			op(1'b1, 1'b0, 1'b0, 16'h0000, 8'h00);
			op(1'b0, 1'b1, 1'b0, 16'h0000, {5'(n), 1'b0, d[0][1:0]});
			op(1'b0, 1'b0, 1'b0, 16'h0000, 8'h00);
			boot_start = 1'b1;
			@(negedge core_clk);
			boot_start = 1'b0;
			for (int i = 0; i <= n; i++) begin
				eq.push_back(i < n ? 2'b01 : 2'b10);
				i_boot_fault_model.hit(0);
				@(negedge core_clk);
			end
			chk("failure", 16'h0001, 16'(boot_load_failure));
			pulse_clear();
		end
		for (int k = 1; k < 5; k++) begin
			boot_start = 1'b1;
			@(negedge core_clk);
			boot_start = 1'b0;
			eq.push_back(2'b10);
			i_boot_fault_model.hit(k);
			@(negedge core_clk);
			chk("failure", 16'h0001, 16'(boot_load_failure));
			pulse_clear();
		end
		rst = 1'b1;
		repeat (2) @(negedge core_clk);
		rst = 1'b0;
		op(1'b1, 1'b0, 1'b0, 16'h0000, 8'h00);
		rd({RST_RETRY, 1'b0, f_otp_n, f_ext_n}, 8'hFB);
		op(1'b0, 1'b0, 1'b0, 16'h0000, 8'h00);
		repeat (4) @(negedge core_clk);
		chk("pending", 16'h0000, 16'(rq.size() + eq.size()));
		stop_test();
	end
endmodule : startup_and_id_register_bank_tb
`default_nettype wire
